// [core/mr_host_ctrl.sv]
// Host controller that programs MR0..MR3 and runs the DLL-off switch
// Contract
// - MR2 write: all strobes low, BA=010
// - MR2 reserved pins driven zero
// - MR3 write: all strobes low, BA=011
// - MR3 reserved pins driven zero
// - Enable MPR via MR3 A2 when idle
// - MPR on: only reads and MR3 writes
// - DLL-off needs CL and CWL six; code forces the MR2 CWL code and clears MR2 Rtt_WR, MR0 is sent as software wrote it
// - DLL-off: MR1 A0, tMOD, self refresh
// - Hold CKE high, ODT low after exit
// - Reprogram registers after tXS, wait tMOD
`timescale 1ns/100ps
module mr_host_ctrl #(
  parameter int t_mod = mr_host_pkg::t_mod_ck,
  parameter int t_mrd = mr_host_pkg::t_mrd_ck,
  parameter int t_cksre = mr_host_pkg::t_cksre_ck,
  parameter int t_cksrx = mr_host_pkg::t_cksrx_ck,
  parameter int t_xs = mr_host_pkg::t_xs_ck,
  parameter logic [2:0] cwl_six_code = 3'h1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Memory command pins
  output logic ck,
  output logic cke,
  output logic odt,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [14:0] addr
);

  // Elaboration check of the waits against the 10-bit counter
  if (t_mod < 1 || t_mrd < 1 || t_cksre < 1 || t_cksrx < 1 || t_xs < 1 ||
      t_mod > 1023 || t_mrd > 1023 || t_cksre > 1023 || t_cksrx > 1023 ||
      t_xs > 1023)
  begin : g_bad_wait
    $error("mr_host_ctrl: waits must lie in 1..1023 link cycles");
  end

  typedef enum logic [3:0] {
    s_idle, s_single, s_wait_one, s_mr1_off, s_wait_mod, s_sre, s_wait_sre,
    s_wait_srx, s_srx, s_wait_xs, s_mr0, s_wait_mrd, s_mr2, s_wait_end
  } state_t;

  localparam int a_pasr_lo_w = mr_host_pkg::a_pasr_lo;

  // Pins of an MR2 write; reserved pins forced low
  function automatic logic [14:0] mr2_pins(input logic [10:0] cfg);
    logic [14:0] p;
    p = 15'h0000;
    p[a_pasr_lo_w +: 3] = cfg[2:0];
    p[mr_host_pkg::a_cwl_lo +: 3] = cfg[5:3];
    p[mr_host_pkg::a_asr] = cfg[6];
    p[mr_host_pkg::a_srt] = cfg[7];
    p[mr_host_pkg::a_rtt_wr_lo +: 2] = cfg[10:9];
    return p;
  endfunction : mr2_pins

  logic ck_fall;
  logic slow_q, slow_d;
  logic resp_q, resp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [10:0] mr2_q, mr2_d;
  logic [2:0] mr3_q, mr3_d;
  logic [12:0] mr1_q, mr1_d;
  logic [12:0] mr0_q, mr0_d;
  logic err_q, err_d;
  logic mpr_q, mpr_d;
  logic dll_off_q, dll_off_d;
  state_t st_q, st_d;
  logic [9:0] cnt_q, cnt_d;
  mr_host_pkg::op_t op_q, op_d;
  logic cke_q, cke_d;
  logic odt_q, odt_d;
  logic [3:0] cmd_q, cmd_d;
  logic [2:0] ba_q, ba_d;
  logic [14:0] addr_q, addr_d;
  logic wr_fire, start_ok;
  mr_host_pkg::op_t new_op;

  ck_divider #(
    .half_fast(mr_host_pkg::ck_half_fast),
    .half_slow(mr_host_pkg::ck_half_slow)
  ) u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .slow(slow_q),
    .ck(ck),
    .ck_fall(ck_fall)
  );

  // Bus handshake: every access answered at the second edge
  assign waitrequest = (read || write) && !resp_q;
  assign wr_fire = write && resp_q;
  assign new_op = mr_host_pkg::op_t'(writedata[2:0]);
  // MPR mode admits reads and MR3 writes
  assign start_ok = (st_q == s_idle) && (!mpr_q || new_op == mr_host_pkg::op_read ||
    new_op == mr_host_pkg::op_mr3 || new_op == mr_host_pkg::op_nop ||
    new_op == mr_host_pkg::op_desel);

  // Register file next values
  always_comb
  begin
    resp_d = (read || write) && !resp_q;
    rdata_d = rdata_q;
    mr2_d = mr2_q;
    mr3_d = mr3_q;
    mr1_d = mr1_q;
    mr0_d = mr0_q;
    err_d = err_q;
    if (read && !resp_q)
    begin
      case (address)
        mr_host_pkg::reg_mr2_cfg: rdata_d = {21'h000000, mr2_q};
        mr_host_pkg::reg_mr3_cfg: rdata_d = {29'h00000000, mr3_q};
        mr_host_pkg::reg_mr1_cfg: rdata_d = {19'h00000, mr1_q};
        mr_host_pkg::reg_mr0_cfg: rdata_d = {19'h00000, mr0_q};
        mr_host_pkg::reg_status:
        begin
          rdata_d = 32'h00000000;
          rdata_d[mr_host_pkg::st_busy_bit] = (st_q != s_idle);
          rdata_d[mr_host_pkg::st_mpr_bit] = mpr_q;
          rdata_d[mr_host_pkg::st_dll_off_bit] = dll_off_q;
          rdata_d[mr_host_pkg::st_err_bit] = err_q;
          rdata_d[mr_host_pkg::st_slow_bit] = slow_q;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (wr_fire)
    begin
      case (address)
        mr_host_pkg::reg_mr2_cfg: mr2_d = writedata[10:0];
        mr_host_pkg::reg_mr3_cfg: mr3_d = writedata[2:0];
        mr_host_pkg::reg_mr1_cfg: mr1_d = writedata[12:0];
        mr_host_pkg::reg_mr0_cfg: mr0_d = writedata[12:0];
        mr_host_pkg::reg_status:
          if (writedata[mr_host_pkg::st_err_bit])
            err_d = 1'b0;
        default: ;
      endcase
    end
    // Refused order sets error; set wins over clear
    if (wr_fire && address == mr_host_pkg::reg_ctrl && !start_ok)
      err_d = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      resp_q <= 1'b0;
      rdata_q <= 32'h00000000;
      mr2_q <= mr_host_pkg::mr2_cfg_rst;
      mr3_q <= mr_host_pkg::mr3_cfg_rst;
      mr1_q <= mr_host_pkg::mr1_cfg_rst;
      mr0_q <= mr_host_pkg::mr0_cfg_rst;
      err_q <= 1'b0;
    end
    else
    begin
      resp_q <= resp_d;
      rdata_q <= rdata_d;
      mr2_q <= mr2_d;
      mr3_q <= mr3_d;
      mr1_q <= mr1_d;
      mr0_q <= mr0_d;
      err_q <= err_d;
    end
  end

  assign readdata = rdata_q;

  // Sequencer next values; pins change only at link falling edges
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    op_d = op_q;
    slow_d = slow_q;
    mpr_d = mpr_q;
    dll_off_d = dll_off_q;
    cke_d = cke_q;
    odt_d = odt_q;
    cmd_d = cmd_q;
    ba_d = ba_q;
    addr_d = addr_q;
    if (st_q == s_idle && wr_fire && address == mr_host_pkg::reg_ctrl && start_ok)
    begin
      op_d = new_op;
      st_d = (new_op == mr_host_pkg::op_dll_off) ? s_mr1_off : s_single;
    end
    else if (ck_fall)
    begin
      cmd_d = mr_host_pkg::cmd_nop;
      ba_d = 3'h0;
      addr_d = 15'h0000;
      if (cnt_q != 10'h000)
        cnt_d = cnt_q - 10'h001;
      case (st_q)
        s_idle: ;
        s_single:
        begin
          cnt_d = 10'(t_mod);
          st_d = s_wait_one;
          case (op_q)
            mr_host_pkg::op_desel: cmd_d = mr_host_pkg::cmd_desel;
            mr_host_pkg::op_mr0:
            begin
              cmd_d = mr_host_pkg::cmd_mrs;
              ba_d = mr_host_pkg::ba_mr0;
              addr_d = {2'b00, mr0_q} & mr_host_pkg::mr0_keep;
            end
            mr_host_pkg::op_mr1:
            begin
              cmd_d = mr_host_pkg::cmd_mrs;
              ba_d = mr_host_pkg::ba_mr1;
              addr_d = {2'b00, mr1_q} & mr_host_pkg::mr1_keep;
              dll_off_d = mr1_q[mr_host_pkg::a_dll_off];
            end
            mr_host_pkg::op_mr2:
            begin
              // MR2 bank code; reserved pins zero
              cmd_d = mr_host_pkg::cmd_mrs;
              ba_d = mr_host_pkg::ba_mr2;
              addr_d = mr2_pins(mr2_q);
            end
            mr_host_pkg::op_mr3:
            begin
              cmd_d = mr_host_pkg::cmd_mrs;
              ba_d = mr_host_pkg::ba_mr3;
              addr_d[mr_host_pkg::a_mpr_loc_lo +: 2] = mr3_q[1:0];
              addr_d[mr_host_pkg::a_mpr_en] = mr3_q[2];
              mpr_d = mr3_q[2];
            end
            mr_host_pkg::op_read:
            begin
              // Read returns pattern while MPR on
              cmd_d = mr_host_pkg::cmd_read;
              cnt_d = 10'(t_mrd);
            end
            default: cnt_d = 10'h001;
          endcase
        end
        s_mr1_off:
        begin
          // Termination off and MR1 with A0 set at the same falling edge
          odt_d = 1'b0;
          cmd_d = mr_host_pkg::cmd_mrs;
          ba_d = mr_host_pkg::ba_mr1;
          addr_d = ({2'b00, mr1_q} & mr_host_pkg::mr1_keep & ~mr_host_pkg::mr1_rtt_nom) |
            15'h0001;
          dll_off_d = 1'b1;
          cnt_d = 10'(t_mod);
          st_d = s_wait_mod;
        end
        s_wait_mod:
          if (cnt_q <= 10'h001)
            st_d = s_sre;
        s_sre:
        begin
          // Self refresh entry, clock enable low
          cmd_d = mr_host_pkg::cmd_refresh;
          cke_d = 1'b0;
          cnt_d = 10'(t_cksre);
          st_d = s_wait_sre;
        end
        s_wait_sre:
          if (cnt_q <= 10'h001)
          begin
            slow_d = 1'b1;
            cnt_d = 10'(t_cksrx);
            st_d = s_wait_srx;
          end
        s_wait_srx:
          if (cnt_q <= 10'h001)
            st_d = s_srx;
        s_srx:
        begin
          // CKE high from exit on, ODT held low
          cke_d = 1'b1;
          odt_d = 1'b0;
          cnt_d = 10'(t_xs);
          st_d = s_wait_xs;
        end
        s_wait_xs:
          if (cnt_q <= 10'h001)
            st_d = s_mr0;
        s_mr0:
        begin
          cmd_d = mr_host_pkg::cmd_mrs;
          ba_d = mr_host_pkg::ba_mr0;
          addr_d = {2'b00, mr0_q} & mr_host_pkg::mr0_keep;
          cnt_d = 10'(t_mrd);
          st_d = s_wait_mrd;
        end
        s_wait_mrd:
          if (cnt_q <= 10'h001)
            st_d = s_mr2;
        s_mr2:
        begin
          cmd_d = mr_host_pkg::cmd_mrs;
          ba_d = mr_host_pkg::ba_mr2;
          addr_d = mr2_pins({2'b00, mr2_q[8:6], cwl_six_code, mr2_q[2:0]});
          cnt_d = 10'(t_mod);
          st_d = s_wait_end;
        end
        s_wait_end, s_wait_one:
          if (cnt_q <= 10'h001)
            st_d = s_idle;
        default: st_d = s_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= s_idle;
      cnt_q <= 10'h000;
      op_q <= mr_host_pkg::op_nop;
      slow_q <= 1'b0;
      mpr_q <= 1'b0;
      dll_off_q <= 1'b0;
      cke_q <= 1'b1;
      odt_q <= 1'b0;
      cmd_q <= mr_host_pkg::cmd_desel;
      ba_q <= 3'h0;
      addr_q <= 15'h0000;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      slow_q <= slow_d;
      mpr_q <= mpr_d;
      dll_off_q <= dll_off_d;
      cke_q <= cke_d;
      odt_q <= odt_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
    end
  end

  // Pin outputs straight from flip-flops
  assign cke = cke_q;
  assign odt = odt_q;
  assign cs_n = cmd_q[3];
  assign ras_n = cmd_q[2];
  assign cas_n = cmd_q[1];
  assign we_n = cmd_q[0];
  assign ba = ba_q;
  assign addr = addr_q;

endmodule : mr_host_ctrl

// [shared/mr_host_pkg.sv]
// Constants and types shared by the mode register host controller
package mr_host_pkg;

  // Avalon word indices of the controller's own registers
  localparam logic [2:0] reg_ctrl = 3'h0;
  localparam logic [2:0] reg_mr2_cfg = 3'h1;
  localparam logic [2:0] reg_mr3_cfg = 3'h2;
  localparam logic [2:0] reg_mr1_cfg = 3'h3;
  localparam logic [2:0] reg_mr0_cfg = 3'h4;
  localparam logic [2:0] reg_status = 3'h5;

  // Reset values of the configuration registers
  localparam logic [10:0] mr2_cfg_rst = 11'h000;
  localparam logic [2:0] mr3_cfg_rst = 3'h0;
  localparam logic [12:0] mr1_cfg_rst = 13'h0000;
  localparam logic [12:0] mr0_cfg_rst = 13'h0000;

  // Status register bit positions
  localparam int st_busy_bit = 0;
  localparam int st_mpr_bit = 1;
  localparam int st_dll_off_bit = 2;
  localparam int st_err_bit = 3;
  localparam int st_slow_bit = 4;

  // Mode register field positions on the address pins
  localparam int a_pasr_lo = 0;
  localparam int a_cwl_lo = 3;
  localparam int a_asr = 6;
  localparam int a_srt = 7;
  localparam int a_rtt_wr_lo = 9;
  localparam int a_mpr_loc_lo = 0;
  localparam int a_mpr_en = 2;
  localparam int a_dll_off = 0;

  // Pins that MR0 and MR1 writes may drive, and the MR1 termination pins
  localparam logic [14:0] mr0_keep = 15'h1fff;
  localparam logic [14:0] mr1_keep = 15'h1afb;
  localparam logic [14:0] mr1_rtt_nom = 15'h0244;

  // Bank codes of the mode registers
  localparam logic [2:0] ba_mr0 = 3'h0;
  localparam logic [2:0] ba_mr1 = 3'h1;
  localparam logic [2:0] ba_mr2 = 3'h2;
  localparam logic [2:0] ba_mr3 = 3'h3;

  // Command pin codes: cs_n, ras_n, cas_n, we_n
  localparam logic [3:0] cmd_mrs = 4'h0;
  localparam logic [3:0] cmd_refresh = 4'h1;
  localparam logic [3:0] cmd_read = 4'h5;
  localparam logic [3:0] cmd_nop = 4'h7;
  localparam logic [3:0] cmd_desel = 4'hf;

  // Default waits, in link clock cycles
  localparam int t_mod_ck = 12;
  localparam int t_mrd_ck = 4;
  localparam int t_cksre_ck = 5;
  localparam int t_cksrx_ck = 5;
  localparam int t_xs_ck = 64;

  // Default half periods of the link clock, in sys_clk cycles
  localparam int ck_half_fast = 4;
  localparam int ck_half_slow = 16;

  // Orders that software writes to the control register
  typedef enum logic [2:0] {
    op_nop,
    op_desel,
    op_mr0,
    op_mr1,
    op_mr2,
    op_mr3,
    op_read,
    op_dll_off
  } op_t;

endpackage : mr_host_pkg

// [core/ck_divider.sv]
// Link clock divider with selectable rate and a falling edge enable
`timescale 1ns/100ps
module ck_divider #(
  parameter int half_fast = mr_host_pkg::ck_half_fast,
  parameter int half_slow = mr_host_pkg::ck_half_slow
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Rate select
  input wire logic slow,
  // Link clock out and its falling edge
  output logic ck,
  output logic ck_fall
);

  // Elaboration check of the half periods
  if (half_fast < 1 || half_slow < 1 || half_fast > 255 || half_slow > 255)
  begin : g_bad_half
    $error("ck_divider: half periods must lie in 1..255");
  end

  logic [7:0] cnt_q, cnt_d;
  logic ck_q, ck_d;
  logic [7:0] limit;

  // Half period count; new rate applies to the half period in progress
  always_comb
  begin
    limit = slow ? 8'(half_slow - 1) : 8'(half_fast - 1);
    cnt_d = cnt_q + 8'h01;
    ck_d = ck_q;
    if (cnt_q >= limit)
    begin
      cnt_d = 8'h00;
      ck_d = ~ck_q;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= 8'h00;
      ck_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ck_q <= ck_d;
    end
  end

  assign ck = ck_q;
  // Pins change at the falling edge, stable at the rising one
  assign ck_fall = ck_q && (cnt_q >= limit);

endmodule : ck_divider

// [tb/mr_host_ctrl_assertions.sv]
// Concurrent checks on the host controller's bus and link pins
`timescale 1ns/100ps
module mr_host_ctrl_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Memory command pins
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [14:0] addr
);
  logic [3:0] cmd;
  logic mrs;
  // Command code and mode register write decode
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign mrs = (cmd == mr_host_pkg::cmd_mrs);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  AST_ONE_WAIT: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait state");
  AST_UNMAPPED_ZERO: assert property (read && !waitrequest && address > 3'h5 |-> readdata == 0)
    else $error("unmapped word read nonzero");
  AST_PINS_ON_FALL: assert property (!$stable({cmd, ba, addr}) |-> $fell(ck))
    else $error("command pins moved off a link falling edge");
  AST_CMD_STANDS: assert property ($fell(ck) |=> ($stable({cmd, ba, addr}))[*7])
    else $error("command did not stand a full link period");
  AST_MRS_BA2: assert property (mrs |-> ba[2] == 1'b0)
    else $error("mode register write with bank bit 2 set");
  AST_MR2_RSVD: assert property (mrs && ba == mr_host_pkg::ba_mr2 |->
    addr[14:11] == 4'h0 && !addr[8]) else $error("mr2 reserved pins not zero");
  AST_MR3_RSVD: assert property (mrs && ba == mr_host_pkg::ba_mr3 |->
    addr[14:3] == 12'h0) else $error("mr3 reserved pins not zero");
  AST_SRE_CKE: assert property (cmd == mr_host_pkg::cmd_refresh |-> !cke)
    else $error("self refresh entry without clock enable low");
  AST_ODT_LOW_SR: assert property (!cke |-> !odt)
    else $error("termination high during self refresh");
  AST_CKE_HOLD: assert property ($rose(cke) |-> cke[*8])
    else $error("clock enable dropped soon after self refresh exit");
  // Main scenarios reached
  cover property (mrs && ba == mr_host_pkg::ba_mr3 && addr[2]);
  cover property (!cke);
  cover property (read && !waitrequest);
endmodule : mr_host_ctrl_assertions

bind mr_host_ctrl mr_host_ctrl_assertions u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .ck(ck), .cke(cke), .odt(odt),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

// [tb/mr_dev_model.sv]
// Behavioural memory device that decodes commands on the link
`timescale 1ns/100ps
module mr_dev_model #(
  parameter int cl_six = 6,
  parameter logic [2:0] cwl_six_code = 3'h1
) (
  // Link pins
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [14:0] addr,
  // Decoded state
  output logic [3:0][14:0] mr,
  output logic [7:0] bad_cmds,
  output logic [7:0] pattern_reads,
  // Latencies with CL of six, in link cycles
  output logic [4:0] wr_lat,
  output logic [4:0] rd_start
);
  logic [3:0] cmd;
  logic [4:0] al;
  logic [4:0] cwl;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign al = (mr[1][4:3] == 2'h1) ? 5'(cl_six - 1) :
    (mr[1][4:3] == 2'h2) ? 5'(cl_six - 2) : 5'h00;
  // CWL from MR2 A5..A3; only six known
  assign cwl = (mr[2][5:3] == cwl_six_code) ? 5'(cl_six) : 5'h00;
  assign wr_lat = al + cwl;
  assign rd_start = al + 5'(cl_six) - 5'h01;
  // Commands sampled on the link rising edge
  initial
  begin
    mr = '0;
    bad_cmds = 8'h0;
    pattern_reads = 8'h0;
    forever
    begin
      @(posedge ck);
      // PASR, ASR/SRT, Rtt_WR kept as written
      if (cke && cmd == mr_host_pkg::cmd_mrs)
      begin
        mr[ba[1:0]] <= addr;
        if (ba[2] || (ba[1:0] == 2'h2 && (addr & 15'h7900) != 15'h0) ||
            (ba[1:0] == 2'h3 && addr[14:3] != 12'h0))
          bad_cmds <= bad_cmds + 8'h1;
      end
      if (cke && mr[3][2] && cmd != mr_host_pkg::cmd_nop && !cs_n)
      begin
        if (cmd == mr_host_pkg::cmd_read)
          pattern_reads <= pattern_reads + 8'h1;
        else if (!(cmd == mr_host_pkg::cmd_mrs && ba == mr_host_pkg::ba_mr3))
          bad_cmds <= bad_cmds + 8'h1;
      end
    end
  end
endmodule : mr_dev_model

// [tb/mr_host_ctrl_test.sv]
// Self-checking bench for the mode register host controller
`timescale 1ns/100ps
module mr_host_ctrl_test;
  localparam logic [2:0] cwl_code = 3'h1;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] address = 3'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, ck, cke, odt, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba;
  logic [14:0] addr;
  logic [3:0][14:0] mr;
  logic [7:0] bad_cmds, pattern_reads;
  logic [4:0] wr_lat, rd_start;
  logic [31:0] v, c0, c1, c2;
  int failures = 0;
  int n_checks = 0;

  always #10 sys_clk = ~sys_clk;

  mr_host_ctrl #(.t_mod(2), .t_mrd(2), .t_cksre(2), .t_cksrx(2), .t_xs(2),
    .cwl_six_code(cwl_code)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ck(ck), .cke(cke), .odt(odt),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
  mr_dev_model #(.cl_six(6), .cwl_six_code(cwl_code)) u_mem (.ck(ck), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .mr(mr), .bad_cmds(bad_cmds),
    .pattern_reads(pattern_reads), .wr_lat(wr_lat), .rd_start(rd_start));

  // Expected pin images of mode register 2, as written and after DLL-off
  function automatic logic [31:0] exp_mr2(input logic [31:0] c);
    return {17'h0, 4'h0, c[10:9], 1'b0, c[7:0]};
  endfunction : exp_mr2
  function automatic logic [31:0] exp_mr2_dll(input logic [31:0] c);
    return {17'h0, 7'h0, c[7:6], cwl_code, c[2:0]};
  endfunction : exp_mr2_dll
  // Additive latency for a CL of six
  function automatic logic [31:0] exp_al(input logic [1:0] code);
    return (code == 2'h1) ? 32'h5 : (code == 2'h2) ? 32'h4 : 32'h0;
  endfunction : exp_al

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Avalon master cycles, held until waitrequest low
  task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus_wr
  task automatic bus_rd(input logic [2:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    d = readdata;
    read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus_rd

  // Order an operation and poll until busy clears
  task automatic run_op(input mr_host_pkg::op_t op);
    logic [31:0] s;
    bus_wr(mr_host_pkg::reg_ctrl, {29'h0, op});
    s = 32'h1;
    while (s[0] !== 1'b0) bus_rd(mr_host_pkg::reg_status, s);
  endtask : run_op

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // Watchdog against a hung handshake
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'ha5b1ed69));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // All words zero after reset; unmapped write ignored
    bus_wr(3'h7, 32'hffffffff);
    for (int i = 0; i < 8; i++)
    begin
      bus_rd(i[2:0], v);
      chk("reset word", 32'h0, v);
    end
    // Mode register 2 with reserved bits set first
    for (int i = 0; i < 3; i++)
    begin
      c2 = (i == 0) ? 32'hffffffff : $urandom();
      bus_wr(mr_host_pkg::reg_mr2_cfg, c2);
      run_op(mr_host_pkg::op_mr2);
      chk("mr2", exp_mr2(c2), {17'h0, mr[2]});
    end
    run_op(mr_host_pkg::op_nop);
    run_op(mr_host_pkg::op_desel);
    chk("mr2 kept", exp_mr2(c2), {17'h0, mr[2]});
    // Order while busy is refused
    bus_wr(mr_host_pkg::reg_ctrl, {29'h0, mr_host_pkg::op_mr2});
    bus_wr(mr_host_pkg::reg_ctrl, {29'h0, mr_host_pkg::op_mr2});
    bus_rd(mr_host_pkg::reg_status, v);
    chk("busy refusal", 32'h1, {31'h0, v[3]});
    run_op(mr_host_pkg::op_nop);
    bus_wr(mr_host_pkg::reg_status, 32'h8);
    // Pattern mode: only reads and mode register 3 writes
    c1 = {29'h0, 1'b1, 2'($urandom())};
    bus_wr(mr_host_pkg::reg_mr3_cfg, c1);
    run_op(mr_host_pkg::op_mr3);
    chk("mr3 on", c1, {17'h0, mr[3]});
    bus_wr(mr_host_pkg::reg_ctrl, {29'h0, mr_host_pkg::op_mr2});
    bus_rd(mr_host_pkg::reg_status, v);
    chk("status refused", 32'ha, v);
    bus_wr(mr_host_pkg::reg_status, 32'h8);
    run_op(mr_host_pkg::op_read);
    chk("pattern reads", 32'h1, {24'h0, pattern_reads});
    c1 = {29'h0, 1'b0, 2'($urandom())};
    bus_wr(mr_host_pkg::reg_mr3_cfg, c1);
    run_op(mr_host_pkg::op_mr3);
    chk("mr3 off", c1, {17'h0, mr[3]});
    bus_rd(mr_host_pkg::reg_status, v);
    chk("status idle", 32'h0, v);
    // DLL disable bit set and cleared by single writes
    for (int i = 1; i >= 0; i--)
    begin
      c1 = ($urandom() & 32'hfffffffe) | i;
      bus_wr(mr_host_pkg::reg_mr1_cfg, c1);
      run_op(mr_host_pkg::op_mr1);
      chk("mr1", {17'h0, c1[14:0] & mr_host_pkg::mr1_keep}, {17'h0, mr[1]});
      bus_rd(mr_host_pkg::reg_status, v);
      chk("dll status", 32'(i) << 2, v);
    end
    // Full switch to DLL-off with termination and dynamic termination set
    c0 = $urandom();
    c1 = $urandom() | 32'h244;
    if (c1[4:3] == 2'h3) c1[4] = 1'b0;
    c2 = $urandom() | 32'h600;
    bus_wr(mr_host_pkg::reg_mr0_cfg, c0);
    bus_wr(mr_host_pkg::reg_mr1_cfg, c1);
    bus_wr(mr_host_pkg::reg_mr2_cfg, c2);
    run_op(mr_host_pkg::op_dll_off);
    chk("mr1 dll", {17'h0, (c1[14:0] & mr_host_pkg::mr1_keep & ~mr_host_pkg::mr1_rtt_nom)
      | 15'h1}, {17'h0, mr[1]});
    chk("mr0 dll", {17'h0, c0[14:0] & mr_host_pkg::mr0_keep}, {17'h0, mr[0]});
    chk("mr2 dll", exp_mr2_dll(c2), {17'h0, mr[2]});
    chk("write latency", exp_al(c1[4:3]) + 32'h6, {27'h0, wr_lat});
    chk("read start", exp_al(c1[4:3]) + 32'h5, {27'h0, rd_start});
    bus_rd(mr_host_pkg::reg_status, v);
    chk("status dll", 32'h14, v);
    chk("bad commands", 32'h0, {24'h0, bad_cmds});
    conclude();
  end
endmodule : mr_host_ctrl_test
